// >>> logic/timer_flag_skip_instr_decode.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Timer B enable clear, flag set: skip
// - That case also clears timer B flag
// - Timer B flag clear: no skip
// - Timer B enable set: plain no-operation
// - Timer B enable is first control bit 3
// - Timer C enable clear, flag set: skip
// - Clears timer C flag; clear flag no skip
// - Timer C enable set: plain no-operation
// - Timer C enable is second control bit 0
// - Timer C test opcode is 1010000010
module timer_flag_skip_instr_decode
    import skip_decode_pkg::*;
#(
    parameter logic [9:0] OPC_SOFTWARE_SYSTEM_RESET_OP = OPC_SOFTWARE_SYSTEM_RESET_OP_DEF
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output var  logic [DATA_W-1:0] prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              instr_strobe,
    input  wire logic [OPC_W-1:0]  instr_word,
    input  wire logic              tmr_b_event,
    input  wire logic              tmr_c_event,
    output var  logic              skip_next,
    output var  logic              tmr_b_request_flag,
    output var  logic              tmr_c_request_flag,
    output var  logic              tmr_b_irq_enable,
    output var  logic              tmr_c_irq_enable,
    output var  logic              sys_reset_req,
    output var  logic              irq
);

    // Maps a word address onto a register select
    // Only whole aligned words are mapped; an offset inside a word falls
    // to the default and is refused like any other unmapped address
    function automatic reg_sel_t addr_decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        unique case (addr)
            OFS_IRQ_CONTROL_FIRST:  sel = SEL_CTRL1;
            OFS_IRQ_CONTROL_SECOND: sel = SEL_CTRL2;
            OFS_FLAGS:              sel = SEL_FLAGS;
            OFS_INT_STATUS:         sel = SEL_STAT;
            OFS_INT_MASK:           sel = SEL_MASK;
            OFS_SKIP_COUNT:         sel = SEL_CNT;
            default:                sel = SEL_NONE;  // Unmapped address
        endcase
        return sel;
    endfunction : addr_decode

    // Decoded instruction strobes
    // Registered in the decoder, so each opcode gives a one-clock pulse
    decode_if dec ();

    // Software visible state
    logic [CTRL_W-1:0] irq_control_first;   // Holds the timer B enable
    logic [CTRL_W-1:0] irq_control_second;  // Holds the timer C enable
    logic [STAT_W-1:0] int_status;          // Sticky events
    logic [STAT_W-1:0] int_mask;            // Interrupt gate
    logic [CNT_W-1:0]  skip_count;          // Skips taken, wraps

    // Reset request sequencer
    rst_state_t        rst_state;           // Idle or holding the request
    logic [HOLD_W-1:0] hold_count;          // Clocks left in the pulse

    // Bus phase qualifiers
    // All but acc_sel low while the bus is idle; only a selected transfer moves them
    logic              apb_setup;           // First cycle of a transfer
    logic              apb_done;            // Edge at which a transfer completes
    logic              apb_wr;              // Completing write
    logic              apb_rd_stat;         // Completing read of status
    reg_sel_t          acc_sel;             // Register addressed now

    // Execution qualifiers
    // All but next_int_status valid only in the execute cycle, the clock after the strobe
    logic              exec_b;              // Timer B test may act
    logic              exec_c;              // Timer C test may act
    logic              hit_b;               // Timer B test skips
    logic              hit_c;               // Timer C test skips
    logic [STAT_W-1:0] status_events;       // Events raised this cycle
    logic [STAT_W-1:0] next_int_status;     // Status after this edge

    // Opcode decode lives in its own stage
    // The reset opcode is a parameter so it can follow the final code map
    instr_opcode_decoder #(
        .OPC_SOFTWARE_SYSTEM_RESET_OP     (OPC_SOFTWARE_SYSTEM_RESET_OP)
    ) u_decoder (
        .clk          (clk),
        .reset        (reset),
        .instr_strobe (instr_strobe),
        .instr_word   (instr_word),
        .dec          (dec)
    );

    // Bus phase decode
    // Completion needs pready as well, so a write lands once only even
    // when the master holds the access phase longer than needed
    always_comb begin
        apb_setup   = psel && !penable;
        apb_done    = psel && penable && pready;
        acc_sel     = addr_decode(paddr);
        apb_wr      = apb_done && pwrite;
        apb_rd_stat = apb_done && !pwrite && (acc_sel == SEL_STAT);
    end

    // Instructions are ignored while a system reset is being requested,
    // since the core is about to be reinitialised anyway
    // A test dropped this way is lost, not deferred: the sequencer restarts
    // from reset and never waits for its skip
    always_comb begin
        exec_b = dec.op_skip_b && (rst_state == RST_IDLE);
        exec_c = dec.op_skip_c && (rst_state == RST_IDLE);
        // Enable clear and flag set is the only case that skips
        hit_b  = exec_b && !tmr_b_irq_enable && tmr_b_request_flag;
        hit_c  = exec_c && !tmr_c_irq_enable && tmr_c_request_flag;
    end

    // Enable bits are taken straight from their register positions
    // The copy costs one clock: a control write lands at one edge and the
    // copy follows at the next, so software must write at least two
    // clocks before a test that depends on the new setting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmr_b_irq_enable <= 1'b0;
            tmr_c_irq_enable <= 1'b0;
        end else begin
            tmr_b_irq_enable <= irq_control_first[TMR_B_EN_BIT];
            tmr_c_irq_enable <= irq_control_second[TMR_C_EN_BIT];
        end
    end

    // Timer B request flag: a timer event wins over the test's clear,
    // so a request landing in the clearing cycle is not lost
    // With no event and no hit the flag holds, which keeps the enabled
    // test a true no-operation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmr_b_request_flag <= 1'b0;
        end else if (tmr_b_event) begin
            tmr_b_request_flag <= 1'b1;
        end else if (hit_b) begin
            tmr_b_request_flag <= 1'b0;
        end
    end

    // Timer C request flag, same priority as timer B
    // Both flags share one form; a change to one belongs in the other
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmr_c_request_flag <= 1'b0;
        end else if (tmr_c_event) begin
            tmr_c_request_flag <= 1'b1;
        end else if (hit_c) begin
            tmr_c_request_flag <= 1'b0;
        end
    end

    // Skip strobe to the program sequencer; one clock per test that skips,
    // two clocks after the instruction strobe
    // The pulse is not held: the sequencer takes it in the cycle it stands,
    // and a second test right behind gives a second pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= hit_b || hit_c;
        end
    end

    // System reset request: held long enough for the whole chip to see it
    // The pulse is counted here rather than fed back into this block's own
    // reset: feeding it back would clear the counter before the pulse
    // had reached the rest of the chip
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_state     <= RST_IDLE;
            hold_count    <= '0;
            sys_reset_req <= 1'b0;
        end else begin
            unique case (rst_state)
                RST_IDLE: begin
                    if (dec.op_reset) begin
                        // Start from the full pulse length
                        rst_state     <= RST_HOLD;
                        hold_count    <= RESET_HOLD_COUNT;
                        sys_reset_req <= 1'b1;
                    end
                end
                RST_HOLD: begin
                    if (hold_count == HOLD_W'(1)) begin
                        // Pulse over; the outer reset takes it from here
                        rst_state     <= RST_IDLE;
                        hold_count    <= '0;
                        sys_reset_req <= 1'b0;
                    end else begin
                        // Still holding; one clock fewer to go
                        hold_count    <= hold_count - HOLD_W'(1);
                    end
                end
            endcase
        end
    end

    // Interrupt control registers, written by software only
    // Only the low four bits exist; higher write data bits are dropped
    // and read back as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_control_first  <= CTRL_RESET;
            irq_control_second <= CTRL_RESET;
        end else if (apb_wr) begin
            if (acc_sel == SEL_CTRL1) begin
                irq_control_first <= pwdata[CTRL_W-1:0];
            end
            if (acc_sel == SEL_CTRL2) begin
                irq_control_second <= pwdata[CTRL_W-1:0];
            end
        end
    end

    // Interrupt mask register
    // A set mask bit lets the matching status bit drive the interrupt
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            int_mask <= MASK_RESET;
        end else if (apb_wr && (acc_sel == SEL_MASK)) begin
            int_mask <= pwdata[STAT_W-1:0];
        end
    end

    // Skip counter; a write of any value clears it
    // The count wraps at its width; software that needs more must poll
    // and clear it before it turns over
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            skip_count <= CNT_RESET;
        end else if (apb_wr && (acc_sel == SEL_CNT)) begin
            skip_count <= CNT_RESET;
        end else if (hit_b || hit_c) begin
            skip_count <= skip_count + CNT_W'(1);
        end
    end

    // Status events and read-to-clear; an event in the clearing read
    // survives, because the set is ORed in after the clear
    // Repeated events before a read merge into one bit; the skip counter
    // is there for software that needs the number
    always_comb begin
        status_events                  = '0;
        status_events[STAT_SKIP_B_BIT] = hit_b;
        status_events[STAT_SKIP_C_BIT] = hit_c;
        status_events[STAT_SOFTWARE_SYSTEM_RESET_OP_BIT]   = dec.op_reset && (rst_state == RST_IDLE);
        if (apb_rd_stat) begin
            next_int_status = status_events;
        end else begin
            next_int_status = int_status | status_events;
        end
    end

    // Sticky status register
    // Every bit holds until a read of the status word clears it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            int_status <= STAT_RESET;
        end else begin
            int_status <= next_int_status;
        end
    end

    // Level interrupt; looks at the next status so it tracks it exactly
    // This saves a clock of interrupt latency at the cost of a deeper
    // path from the event terms to this flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_int_status & int_mask);
        end
    end

    // Slave answers in the first access cycle: ready is raised by the setup
    // cycle, so each transfer takes exactly two clocks
    // Errors ride on the same ready pulse so the master sees them in the
    // access cycle; a refused write changes nothing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && (acc_sel == SEL_NONE);
        end
    end

    // Read data captured in the setup cycle; status bits still arriving in
    // the access cycle are kept for the next read rather than lost
    // Data stand from the access cycle until the next read setup, so a
    // master that samples late still sees them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= '0;
        end else if (apb_setup && !pwrite) begin
            prdata <= '0;
            unique case (acc_sel)
                SEL_CTRL1: begin
                    prdata[CTRL_W-1:0] <= irq_control_first;
                end
                SEL_CTRL2: begin
                    prdata[CTRL_W-1:0] <= irq_control_second;
                end
                SEL_FLAGS: begin
                    prdata[FLAG_B_BIT] <= tmr_b_request_flag;
                    prdata[FLAG_C_BIT] <= tmr_c_request_flag;
                end
                SEL_STAT: begin
                    prdata[STAT_W-1:0] <= next_int_status;
                end
                SEL_MASK: begin
                    prdata[STAT_W-1:0] <= int_mask;
                end
                SEL_CNT: begin
                    prdata[CNT_W-1:0] <= skip_count;
                end
                default: begin
                    prdata <= '0;  // Unmapped reads as zero
                end
            endcase
        end
    end

endmodule : timer_flag_skip_instr_decode

`default_nettype wire

// >>> logic/skip_decode_pkg.sv
package skip_decode_pkg;

    // APB geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFS_IRQ_CONTROL_FIRST  = 8'h00;
    localparam logic [7:0] OFS_IRQ_CONTROL_SECOND = 8'h04;
    localparam logic [7:0] OFS_FLAGS              = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS         = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK           = 8'h10;
    localparam logic [7:0] OFS_SKIP_COUNT         = 8'h14;

    // Interrupt control registers are four bits wide
    localparam int unsigned CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Enable bit positions inside the interrupt control registers
    localparam int unsigned TMR_B_EN_BIT = 3;
    localparam int unsigned TMR_C_EN_BIT = 0;

    // Flag register layout
    localparam int unsigned FLAG_B_BIT = 0;
    localparam int unsigned FLAG_C_BIT = 1;

    // Interrupt status and mask layout
    localparam int unsigned STAT_W          = 3;
    localparam int unsigned STAT_SKIP_B_BIT = 0;
    localparam int unsigned STAT_SKIP_C_BIT = 1;
    localparam int unsigned STAT_SOFTWARE_SYSTEM_RESET_OP_BIT   = 2;
    localparam logic [2:0]  STAT_RESET      = 3'h0;
    localparam logic [2:0]  MASK_RESET      = 3'h0;

    // Skip counter width and reset value
    localparam int unsigned CNT_W     = 8;
    localparam logic [7:0]  CNT_RESET = 8'h00;

    // Instruction word and opcodes, most significant bit first
    localparam int unsigned OPC_W          = 10;
    localparam logic [9:0]  OPC_SKIP_B     = 10'h281;
    localparam logic [9:0]  OPC_SKIP_C     = 10'h282;
    localparam logic [9:0]  OPC_SOFTWARE_SYSTEM_RESET_OP_DEF   = 10'h003;

    // Length of the internal system reset request pulse, in clocks
    localparam int unsigned HOLD_W           = 4;
    localparam logic [3:0]  RESET_HOLD_COUNT = 4'h8;

    // Register select produced by the address decoder
    typedef enum logic [2:0] {
        SEL_CTRL1,
        SEL_CTRL2,
        SEL_FLAGS,
        SEL_STAT,
        SEL_MASK,
        SEL_CNT,
        SEL_NONE
    } reg_sel_t;

    // Sequencer for the system reset request
    typedef enum logic {
        RST_IDLE,
        RST_HOLD
    } rst_state_t;

endpackage : skip_decode_pkg

// >>> logic/decode_if.sv
`timescale 1ns/10ps
`default_nettype none

// Decoded instruction strobes between decoder and execution logic
interface decode_if;
    logic op_skip_b;   // Timer B flag test, one-cycle pulse
    logic op_skip_c;   // Timer C flag test, one-cycle pulse
    logic op_reset;    // System reset instruction, one-cycle pulse

    modport src (output op_skip_b, output op_skip_c, output op_reset);
    modport dst (input op_skip_b, input op_skip_c, input op_reset);
endinterface : decode_if

`default_nettype wire

// >>> logic/instr_opcode_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module instr_opcode_decoder
    import skip_decode_pkg::*;
#(
    parameter logic [9:0] OPC_SOFTWARE_SYSTEM_RESET_OP = OPC_SOFTWARE_SYSTEM_RESET_OP_DEF
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             instr_strobe,
    input  wire logic [OPC_W-1:0] instr_word,
    decode_if.src                 dec
);

    // Registered decode; one word per instruction, no operand fetch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dec.op_skip_b <= 1'b0;
            dec.op_skip_c <= 1'b0;
            dec.op_reset  <= 1'b0;
        end else begin
            dec.op_skip_b <= instr_strobe && (instr_word == OPC_SKIP_B);
            dec.op_skip_c <= instr_strobe && (instr_word == OPC_SKIP_C);
            dec.op_reset  <= instr_strobe && (instr_word == OPC_SOFTWARE_SYSTEM_RESET_OP);
        end
    end

endmodule : instr_opcode_decoder

`default_nettype wire

// >>> verif/skip_checker.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the ports of timer_flag_skip_instr_decode only
module skip_checker
    import skip_decode_pkg::*;
#(
    parameter logic [9:0] OPC_SOFTWARE_SYSTEM_RESET_OP = OPC_SOFTWARE_SYSTEM_RESET_OP_DEF
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        instr_strobe,
    input wire logic [9:0]  instr_word,
    input wire logic        tmr_b_event,
    input wire logic        tmr_c_event,
    input wire logic        skip_next,
    input wire logic        tmr_b_request_flag,
    input wire logic        tmr_c_request_flag,
    input wire logic        tmr_b_irq_enable,
    input wire logic        tmr_c_irq_enable,
    input wire logic        sys_reset_req
);
    logic st_b;  // Timer B test taken
    logic st_c;  // Timer C test taken
    logic nb;    // Timer B quiet, enable clear
    logic nc;    // Timer C quiet, enable clear
    logic wr;    // APB write completes
    assign st_b = instr_strobe && instr_word == OPC_SKIP_B && !sys_reset_req;
    assign st_c = instr_strobe && instr_word == OPC_SKIP_C && !sys_reset_req;
    assign nb = !tmr_b_irq_enable && !tmr_b_event && !sys_reset_req;
    assign nc = !tmr_c_irq_enable && !tmr_c_event && !sys_reset_req;
    assign wr = psel && penable && pready && pwrite;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Enable copy lags the register by one clock
    a_en_b_copy: assert property (wr && paddr == OFS_IRQ_CONTROL_FIRST |->
        ##2 tmr_b_irq_enable == $past(pwdata[3], 2)) else $error("timer B enable bit wrong");
    a_en_c_copy: assert property (wr && paddr == OFS_IRQ_CONTROL_SECOND |->
        ##2 tmr_c_irq_enable == $past(pwdata[0], 2)) else $error("timer C enable bit wrong");
    a_skip_b_taken: assert property (st_b && nb ##1 nb && tmr_b_request_flag
        |=> skip_next && !tmr_b_request_flag) else $error("timer B test missed skip");
    a_skip_b_none: assert property (st_b && nb ##1 nb && !tmr_b_request_flag
        |=> !skip_next) else $error("timer B test skipped on clear flag");
    a_skip_b_nop: assert property (st_b && tmr_b_irq_enable ##1 tmr_b_irq_enable
        && !tmr_b_event |=> !skip_next && $stable(tmr_b_request_flag)) else $error("B nop");
    a_skip_c_taken: assert property (st_c && nc ##1 nc && tmr_c_request_flag
        |=> skip_next && !tmr_c_request_flag) else $error("timer C test missed skip");
    a_skip_c_none: assert property (st_c && nc ##1 nc && !tmr_c_request_flag
        |=> !skip_next) else $error("timer C test skipped on clear flag");
    a_skip_c_nop: assert property (st_c && tmr_c_irq_enable ##1 tmr_c_irq_enable
        && !tmr_c_event |=> !skip_next && $stable(tmr_c_request_flag)) else $error("C nop");
    a_rst_starts: assert property (instr_strobe && instr_word == OPC_SOFTWARE_SYSTEM_RESET_OP
        |-> ##[1:3] sys_reset_req) else $error("reset instruction gave no request");
    // Request pulse is exactly eight clocks long
    a_rst_length: assert property ($rose(sys_reset_req) |->
        sys_reset_req [*8] ##1 !sys_reset_req) else $error("reset request length wrong");
endmodule : skip_checker

bind timer_flag_skip_instr_decode skip_checker #(.OPC_SOFTWARE_SYSTEM_RESET_OP(OPC_SOFTWARE_SYSTEM_RESET_OP)) i_skip_checker (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata), .instr_strobe(instr_strobe),
    .instr_word(instr_word), .tmr_b_event(tmr_b_event), .tmr_c_event(tmr_c_event),
    .skip_next(skip_next), .tmr_b_request_flag(tmr_b_request_flag),
    .tmr_c_request_flag(tmr_c_request_flag), .tmr_b_irq_enable(tmr_b_irq_enable),
    .tmr_c_irq_enable(tmr_c_irq_enable), .sys_reset_req(sys_reset_req));

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import skip_decode_pkg::*;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic instr_strobe = 0, tmr_b_event = 0, tmr_c_event = 0;
    logic [7:0]  paddr = 0;       // APB address
    logic [31:0] pwdata = 0;      // APB write data
    logic [9:0]  instr_word = 0;  // Opcode under test
    logic [31:0] rd;              // Last read data
    logic        sk;              // Last pslverr seen
    logic        b;               // Timer B when set, else C
    logic [9:0]  op;              // Opcode of this pass
    logic [7:0]  ra;              // Control register of this pass
    logic [3:0]  en;              // Enable bit pattern of this pass
    wire logic [31:0] prdata;
    wire logic pready, pslverr, skip_next, fb, fc, eb, ec, sys_reset_req, irq;
    int err_count = 0, n_compared = 0, cyc = 0, n;

    timer_flag_skip_instr_decode i_timer_flag_skip_instr_decode (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_strobe(instr_strobe), .instr_word(instr_word),
        .tmr_b_event(tmr_b_event), .tmr_c_event(tmr_c_event), .skip_next(skip_next),
        .tmr_b_request_flag(fb), .tmr_c_request_flag(fc), .tmr_b_irq_enable(eb),
        .tmr_c_irq_enable(ec), .sys_reset_req(sys_reset_req), .irq(irq));

    always #20 clk = ~clk;

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : chk

    // One APB transfer; values read right after an edge are pre-edge values
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // If pready never rises, only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        sk = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Timer event pulse, returns once the flag is visible
    task automatic ev();
        @(posedge clk);
        if (b) tmr_b_event <= 1;
        else tmr_c_event <= 1;
        @(posedge clk);
        tmr_b_event <= 0;
        tmr_c_event <= 0;
        @(posedge clk);
    endtask : ev

    // Issue one test opcode and compare skip pulse and flag in cycle c2
    task automatic test(input logic s, input logic f);
        @(posedge clk);
        instr_strobe <= 1;
        instr_word <= op;
        @(posedge clk);
        instr_strobe <= 0;
        repeat (2) @(posedge clk);
        chk(skip_next, s, "skip pulse");
        chk(b ? fb : fc, f, "request flag");
    endtask : test

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (4) @(posedge clk);
        reset <= 0;
        // Reset values, then the unmapped word must be refused
        for (int i = 0; i < 6; i++) begin
            apb(0, 8'(i * 4), 0);
            chk(rd, 0, "reset value");
        end
        apb(0, 8'h18, 0);
        chk({rd[30:0], sk}, 1, "unmapped read");
        apb(1, OFS_IRQ_CONTROL_FIRST, 32'hFFFFFFFF);
        apb(0, OFS_IRQ_CONTROL_FIRST, 0);
        chk(rd, 32'h0000000F, "control readback");
        apb(1, OFS_INT_MASK, 32'h1);
        $display("test registers done");
        // Pass 0 timer B, pass 1 timer C; other enable-register bits set for the first skip only
        for (int i = 0; i < 2; i++) begin
            b = (i == 0);
            op = b ? OPC_SKIP_B : OPC_SKIP_C;
            ra = b ? OFS_IRQ_CONTROL_FIRST : OFS_IRQ_CONTROL_SECOND;
            en = b ? 4'h8 : 4'h1;
            apb(1, ra, {28'h0, ~en});
            ev();
            test(1, 0);
            @(posedge clk);
            chk(irq, b, "irq after skip");
            apb(0, OFS_INT_STATUS, 0);
            chk(rd, b ? 32'h1 : 32'h2, "status bit");
            apb(0, OFS_INT_STATUS, 0);
            chk(rd, 0, "status cleared");
            chk(irq, 0, "irq cleared");
            test(0, 0);
            apb(1, ra, {28'h0, en});
            ev();
            chk(b ? eb : ec, 1, "enable copy");
            test(0, 1);
            apb(1, ra, 0);
            ev();
            test(1, 0);
            apb(0, OFS_INT_STATUS, 0);
            chk(rd, b ? 32'h1 : 32'h2, "status after second skip");
            $display("test timer pass %0d done", i);
        end
        apb(0, OFS_SKIP_COUNT, 0);
        chk(rd, 32'h4, "skip count");
        // Reset instruction: request high for exactly eight clocks
        @(posedge clk);
        instr_strobe <= 1;
        instr_word <= OPC_SOFTWARE_SYSTEM_RESET_OP_DEF;
        @(posedge clk);
        instr_strobe <= 0;
        n = 0;
        repeat (14) begin
            @(posedge clk);
            n += int'(sys_reset_req === 1'b1);
        end
        chk(n, 8, "reset request length");
        $display("test reset instruction done");
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
